// ---- shared/mgmt_bits_pkg.sv ----
// constants and types shared by the management register bit cells
package mgmt_bits_pkg;
  // register indices on the management port
  localparam logic [0:0]  REG_CTRL_IDX      = 1'h0;
  localparam logic [0:0]  REG_STRAP_IDX     = 1'h1;
  // field positions in the control/status register
  localparam int          SOFT_RST_POS      = 15;
  localparam int          OVERRIDE_POS      = 14;
  localparam int          LMAX_MSB_POS      = 13;
  localparam int          LMAX_LSB_POS      = 11;
  localparam int          TRIGGER_POS       = 10;
  localparam int          GATED_MSB_POS     = 9;
  localparam int          GATED_LSB_POS     = 8;
  localparam int          WZ_MSB_POS        = 7;
  localparam int          WZ_LSB_POS        = 6;
  localparam int          LHIGH_POS         = 5;
  localparam int          LLOW_POS          = 4;
  localparam int          PLAIN_RW_POS      = 3;
  localparam int          NODEF_POS         = 2;
  // field widths
  localparam int          LMAX_W            = 3;
  localparam int          GATED_W           = 2;
  localparam int          WZ_W              = 2;
  localparam int          STRAP_W           = 5;
  // values after reset
  localparam logic        SOFT_RST_RST      = 1'h0;
  localparam logic        OVERRIDE_RST      = 1'h0;
  localparam logic        TRIGGER_RST       = 1'h0;
  localparam logic [1:0]  GATED_RST         = 2'h0;
  localparam logic [1:0]  WZ_RST            = 2'h3;
  localparam logic        LHIGH_RST         = 1'h0;
  localparam logic        LLOW_RST          = 1'h1;
  localparam logic [2:0]  LMAX_RST          = 3'h0;
  localparam logic        PLAIN_RW_RST      = 1'h1;
  localparam logic [15:0] RDATA_RST         = 16'h0000;
  // software reset duration in cycles of SYS_CLK
  localparam logic [4:0]  SOFT_RST_CYCLES   = 5'h10;
  // software reset sequencer
  typedef enum logic [0:0] {
    SRST_IDLE = 1'b0,
    SRST_RUN  = 1'b1
  } srst_state_t;
endpackage

// ---- rtl/latch_max_group.sv ----
// latching-maximum group: holds the largest tracked state until read
module latch_max_group (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // reload request and tracked state
  input  wire logic                        reload,
  input  wire logic [mgmt_bits_pkg::LMAX_W-1:0] state_in,
  // held value
  output logic [mgmt_bits_pkg::LMAX_W-1:0] max_out
);
  import mgmt_bits_pkg::*;

  logic [LMAX_W-1:0] max_reg;
  logic [LMAX_W-1:0] max_next;

  // unsigned compare, msb first; a read reloads the present state
  always_comb begin
    if (reload) begin
      max_next = state_in;
    end else if (state_in > max_reg) begin
      max_next = state_in;
    end else begin
      max_next = max_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      max_reg <= LMAX_RST;
    end else begin
      max_reg <= max_next;
    end
  end

  assign max_out = max_reg;
endmodule

// ---- rtl/mgmt_bit_bank.sv ----
// management register bit cells: defaults, straps, latching and self-clearing bits
// Notes on behaviour
// - every bit with a default takes it after any reset.
// - strap-dependent bits take the strap pin level sampled at reset.
// - bits without default are not forced by reset.
// - latch-high bit sets on its condition and holds until reset or read.
// - after reading, latch-high bit reloads the present condition level.
// - latch-low bit clears on its condition and holds until reset or read.
// - after reading, latch-low bit reloads the present active-low level.
// - latch-maximum group keeps the largest tracked state, msb first.
// - smaller states leave the held maximum; larger states replace it.
// - latch-maximum group holds until reset or read, then reloads present state.
// - self-clearing bits reset to zero; writing one starts their function.
// - self-clearing bit returns to zero by itself when the function finishes.
// - writes to read-only bits ignored; write-zero-only bits accept only zero.
// - override-gated bits written only with override set; override clears next write.
// - during software reset, reset bit stays one; writes are blocked and reads return data but do not reload bits.
module mgmt_bit_bank (
  // clock and reset
  input  wire logic                                SYS_CLK,
  input  wire logic                                RST_N,
  // management access
  input  wire logic                                MGMT_RD,
  input  wire logic                                MGMT_WR,
  input  wire logic [0:0]                          MGMT_ADDR,
  input  wire logic [15:0]                         MGMT_WDATA,
  output logic [15:0]                              MGMT_RDATA,
  output logic                                     MGMT_BUSY,
  // monitored conditions, same clock
  input  wire logic                                EVENT_HIGH,
  input  wire logic                                EVENT_LOW_N,
  input  wire logic [mgmt_bits_pkg::LMAX_W-1:0]    TRACK_STATE,
  input  wire logic [mgmt_bits_pkg::WZ_W-1:0]      WZ_SET,
  // triggered function
  output logic                                     FUNC_START,
  input  wire logic                                FUNC_DONE,
  // strap pins, asynchronous
  input  wire logic [mgmt_bits_pkg::STRAP_W-1:0]   STRAP_PINS,
  // control outputs
  output logic [mgmt_bits_pkg::STRAP_W-1:0]        STRAP_ADDR,
  output logic [mgmt_bits_pkg::GATED_W-1:0]        GATED_BITS,
  output logic [mgmt_bits_pkg::WZ_W-1:0]           WZ_BITS,
  output logic                                     PLAIN_RW_BIT,
  output logic                                     NODEF_BIT,
  output logic                                     SOFT_RESET_ACTIVE
);
  import mgmt_bits_pkg::*;

  srst_state_t          srst_state_reg;
  srst_state_t          srst_state_next;
  logic [4:0]           srst_cnt_reg;
  logic                 bank_rst;
  logic                 rd_ok;
  logic                 wr_ok;
  logic                 rd_ctrl;
  logic                 wr_ctrl;
  logic [STRAP_W-1:0]   strap_s1_reg;
  logic [STRAP_W-1:0]   strap_s2_reg;
  logic [STRAP_W-1:0]   strap_s3_reg;
  logic [STRAP_W-1:0]   strap_cap_reg;
  logic                 override_reg;
  logic                 trigger_reg;
  logic [GATED_W-1:0]   gated_reg;
  logic [WZ_W-1:0]      wz_reg;
  logic                 lhigh_reg;
  logic                 llow_reg;
  logic                 plain_rw_reg;
  logic                 nodef_reg;
  logic [LMAX_W-1:0]    lmax_val;
  logic [15:0]          ctrl_view;
  logic [15:0]          rdata_reg;

  // hardware reset or running software reset returns the bank to defaults
  assign bank_rst = !RST_N || (srst_state_reg == SRST_RUN);
  // writes and read reloads are blocked while the software reset runs; read data still updates
  assign rd_ok    = MGMT_RD && (srst_state_reg == SRST_IDLE);
  assign wr_ok    = MGMT_WR && (srst_state_reg == SRST_IDLE);
  assign rd_ctrl  = rd_ok && (MGMT_ADDR == REG_CTRL_IDX);
  assign wr_ctrl  = wr_ok && (MGMT_ADDR == REG_CTRL_IDX);

  // software reset sequencer
  always_comb begin
    srst_state_next = srst_state_reg;
    case (srst_state_reg)
      SRST_IDLE: begin
        if (wr_ctrl && MGMT_WDATA[SOFT_RST_POS]) begin
          srst_state_next = SRST_RUN;
        end
      end
      SRST_RUN: begin
        if (srst_cnt_reg == SOFT_RST_CYCLES - 5'h01) begin
          srst_state_next = SRST_IDLE;
        end
      end
      default: srst_state_next = SRST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      srst_state_reg <= SRST_IDLE;
      srst_cnt_reg   <= 5'h00;
    end else begin
      srst_state_reg <= srst_state_next;
      srst_cnt_reg   <= (srst_state_reg == SRST_RUN) ? srst_cnt_reg + 5'h01 : 5'h00;
    end
  end

  // three-stage synchroniser for the strap pins; no reset needed on a pipe
  always_ff @(posedge SYS_CLK) begin
    strap_s1_reg <= STRAP_PINS;
    strap_s2_reg <= strap_s1_reg;
    strap_s3_reg <= strap_s2_reg;
  end

  // strap level caught while reset is held, per bit once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < STRAP_W; gi++) begin : g_strap
      always_ff @(posedge SYS_CLK) begin
        if (bank_rst && (strap_s2_reg[gi] == strap_s3_reg[gi])) begin
          strap_cap_reg[gi] <= strap_s3_reg[gi];
        end
      end
    end
  endgenerate

  // override bit arms on a write of one and clears itself on the next write
  always_ff @(posedge SYS_CLK) begin
    if (bank_rst) begin
      override_reg <= OVERRIDE_RST;
    end else if (wr_ok) begin
      override_reg <= override_reg ? 1'b0 : (wr_ctrl && MGMT_WDATA[OVERRIDE_POS]);
    end
  end

  // override-gated bits take a write only while armed
  always_ff @(posedge SYS_CLK) begin
    if (bank_rst) begin
      gated_reg <= GATED_RST;
    end else if (wr_ctrl && override_reg) begin
      gated_reg <= MGMT_WDATA[GATED_MSB_POS:GATED_LSB_POS];
    end
  end

  // self-clearing trigger: done wins over a new start in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (bank_rst) begin
      trigger_reg <= TRIGGER_RST;
    end else if (trigger_reg && FUNC_DONE) begin
      trigger_reg <= 1'b0;
    end else if (wr_ctrl && MGMT_WDATA[TRIGGER_POS]) begin
      trigger_reg <= 1'b1;
    end
  end

  // one-cycle start pulse on the write that sets an idle trigger
  assign FUNC_START = wr_ctrl && MGMT_WDATA[TRIGGER_POS] && !trigger_reg;

  // write-zero-only bits: hardware set beats a clearing write
  generate
    for (gi = 0; gi < WZ_W; gi++) begin : g_wz
      always_ff @(posedge SYS_CLK) begin
        if (bank_rst) begin
          wz_reg[gi] <= WZ_RST[gi];
        end else if (WZ_SET[gi]) begin
          wz_reg[gi] <= 1'b1;
        end else if (wr_ctrl && !MGMT_WDATA[WZ_LSB_POS + gi]) begin
          wz_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // latching status bits; a read reloads the live level, so a same-cycle event survives
  always_ff @(posedge SYS_CLK) begin
    if (bank_rst) begin
      lhigh_reg <= LHIGH_RST;
      llow_reg  <= LLOW_RST;
    end else if (rd_ctrl) begin
      lhigh_reg <= EVENT_HIGH;
      llow_reg  <= EVENT_LOW_N;
    end else begin
      lhigh_reg <= lhigh_reg | EVENT_HIGH;
      llow_reg  <= llow_reg & EVENT_LOW_N;
    end
  end

  // plain read/write bit with a default of one
  always_ff @(posedge SYS_CLK) begin
    if (bank_rst) begin
      plain_rw_reg <= PLAIN_RW_RST;
    end else if (wr_ctrl) begin
      plain_rw_reg <= MGMT_WDATA[PLAIN_RW_POS];
    end
  end

  // bit without a default: reset leaves it alone
  always_ff @(posedge SYS_CLK) begin
    if (wr_ctrl) begin
      nodef_reg <= MGMT_WDATA[NODEF_POS];
    end
  end

  // latching-maximum group, reset by either reset
  latch_max_group u_lmax (
    .clk      (SYS_CLK),
    .rst_n    (!bank_rst),
    .reload   (rd_ctrl),
    .state_in (TRACK_STATE),
    .max_out  (lmax_val)
  );

  // read view; reserved bits read zero and ignore writes
  always_comb begin
    ctrl_view                            = 16'h0000;
    ctrl_view[SOFT_RST_POS]              = (srst_state_reg == SRST_RUN);
    ctrl_view[OVERRIDE_POS]              = override_reg;
    ctrl_view[LMAX_MSB_POS:LMAX_LSB_POS] = lmax_val;
    ctrl_view[TRIGGER_POS]               = trigger_reg;
    ctrl_view[GATED_MSB_POS:GATED_LSB_POS] = gated_reg;
    ctrl_view[WZ_MSB_POS:WZ_LSB_POS]     = wz_reg;
    ctrl_view[LHIGH_POS]                 = lhigh_reg;
    ctrl_view[LLOW_POS]                  = llow_reg;
    ctrl_view[PLAIN_RW_POS]              = plain_rw_reg;
    ctrl_view[NODEF_POS]                 = nodef_reg;
  end

  // read data registered; the value shown is the one held before the reload
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rdata_reg <= RDATA_RST;
    end else if (MGMT_RD) begin
      if (MGMT_ADDR == REG_CTRL_IDX) begin
        rdata_reg <= ctrl_view;
      end else begin
        rdata_reg <= {{(16 - STRAP_W){1'b0}}, strap_cap_reg};
      end
    end
  end

  assign MGMT_RDATA        = rdata_reg;
  assign MGMT_BUSY         = (srst_state_reg == SRST_RUN);
  assign SOFT_RESET_ACTIVE = (srst_state_reg == SRST_RUN);
  assign STRAP_ADDR        = strap_cap_reg;
  assign GATED_BITS        = gated_reg;
  assign WZ_BITS           = wz_reg;
  assign PLAIN_RW_BIT      = plain_rw_reg;
  assign NODEF_BIT         = nodef_reg;
endmodule

// ---- tb/mgmt_station_model.sv ----
// station management model: issues reads and writes on the management port
module mgmt_station_model
  import mgmt_bits_pkg::*;
(
  // clock and returned data
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  // requests
  output logic             rd,
  output logic             wr,
  output logic [0:0]       addr,
  output logic [15:0]      wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    addr = REG_CTRL_IDX;
    wdata = 16'h0000;
  end
  // every task starts at a falling edge and ends at the next one
  task automatic do_rd(input logic [0:0] a, output logic [15:0] d);
    rd = 1'b1;
    wr = 1'b0;
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask
  // reserved bits 1:0 always go out as zero so test modes stay untouched
  task automatic do_wr(input logic [0:0] a, input logic [15:0] d);
    wr = 1'b1;
    rd = 1'b0;
    addr = a;
    wdata = d & 16'hFFFC;
    @(negedge clk);
  endtask
  task automatic idle;
    rd = 1'b0;
    wr = 1'b0;
    @(negedge clk);
  endtask
endmodule

// ---- tb/mgmt_bit_bank_sva.sv ----
// port-level assertions for the management bit bank
module mgmt_bit_bank_chk
  import mgmt_bits_pkg::*;
(
  // clock and reset
  input wire logic                                SYS_CLK,
  input wire logic                                RST_N,
  // management access
  input wire logic                                MGMT_RD,
  input wire logic                                MGMT_WR,
  input wire logic [0:0]                          MGMT_ADDR,
  input wire logic [15:0]                         MGMT_WDATA,
  input wire logic [15:0]                         MGMT_RDATA,
  input wire logic                                MGMT_BUSY,
  // monitored and controlled bits
  input wire logic                                EVENT_HIGH,
  input wire logic                                EVENT_LOW_N,
  input wire logic [mgmt_bits_pkg::LMAX_W-1:0]    TRACK_STATE,
  input wire logic [mgmt_bits_pkg::WZ_W-1:0]      WZ_SET,
  input wire logic [mgmt_bits_pkg::WZ_W-1:0]      WZ_BITS,
  input wire logic [mgmt_bits_pkg::GATED_W-1:0]   GATED_BITS,
  input wire logic                                PLAIN_RW_BIT,
  input wire logic                                FUNC_START
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd;
    MGMT_RD && MGMT_ADDR == REG_CTRL_IDX && !MGMT_BUSY;
  endsequence
  // two reads in a row: the second shows what the first reloaded
  sequence s_rd2;
    s_rd ##1 s_rd;
  endsequence
  sequence s_srst;
    MGMT_WR && !MGMT_BUSY && MGMT_ADDR == REG_CTRL_IDX && MGMT_WDATA[SOFT_RST_POS];
  endsequence
  property p_dflt;
    $rose(RST_N) |-> WZ_BITS == WZ_RST && GATED_BITS == GATED_RST && PLAIN_RW_BIT;
  endproperty
  a_dflt: assert property (p_dflt) else $error("defaults missing after reset");
  property p_start;
    FUNC_START |-> MGMT_WR && MGMT_WDATA[TRIGGER_POS] && !MGMT_BUSY && MGMT_ADDR == 1'h0;
  endproperty
  a_start: assert property (p_start) else $error("start without trigger write");
  property p_srst;
    s_srst |=> MGMT_BUSY [*8] ##1 MGMT_BUSY [*8] ##1 !MGMT_BUSY;
  endproperty
  a_srst: assert property (p_srst) else $error("software reset busy span wrong");
  property p_wz;
    MGMT_WR && !MGMT_BUSY && !MGMT_WDATA[SOFT_RST_POS] && WZ_SET == 2'h0
      |=> (WZ_BITS & ~$past(WZ_BITS)) == 2'h0;
  endproperty
  a_wz: assert property (p_wz) else $error("write set a write-zero bit");
  property p_gated;
    $changed(GATED_BITS) |-> $past(MGMT_WR) || MGMT_BUSY || $past(MGMT_BUSY);
  endproperty
  a_gated: assert property (p_gated) else $error("gated bits moved without write");
  property p_lh;
    EVENT_HIGH ##0 s_rd2 |=> MGMT_RDATA[LHIGH_POS];
  endproperty
  a_lh: assert property (p_lh) else $error("latch-high lost live level");
  property p_ll;
    !EVENT_LOW_N ##0 s_rd2 |=> !MGMT_RDATA[LLOW_POS];
  endproperty
  a_ll: assert property (p_ll) else $error("latch-low lost live level");
  property p_lmax;
    s_rd2 |=> MGMT_RDATA[LMAX_MSB_POS:LMAX_LSB_POS] >= $past(TRACK_STATE, 2);
  endproperty
  a_lmax: assert property (p_lmax) else $error("latch-max below reloaded state");
endmodule

bind mgmt_bit_bank mgmt_bit_bank_chk chk (.SYS_CLK, .RST_N, .MGMT_RD, .MGMT_WR, .MGMT_ADDR,
  .MGMT_WDATA, .MGMT_RDATA, .MGMT_BUSY, .EVENT_HIGH, .EVENT_LOW_N, .TRACK_STATE, .WZ_SET,
  .WZ_BITS, .GATED_BITS, .PLAIN_RW_BIT, .FUNC_START);

// ---- tb/mgmt_bit_bank_tb_top.sv ----
// self-checking bench for the management bit bank
module mgmt_bit_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mgmt_bits_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd, wr, busy, ev_high, ev_low_n, start, done, plain, nodef, sra;
  logic [0:0]  addr;
  logic [15:0] wdata, rdata;
  logic [15:0] rdata_unused;
  logic [2:0]  trk;
  logic [1:0]  wz_set, wz, gated;
  logic [4:0]  pins, straps;
  int          bad_count = 0;
  int          n_tests = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  mgmt_station_model sta (.clk(clk), .rdata(rdata), .rd(rd), .wr(wr), .addr(addr),
    .wdata(wdata));
  mgmt_bit_bank uut (.SYS_CLK(clk), .RST_N(rst_n), .MGMT_RD(rd), .MGMT_WR(wr),
    .MGMT_ADDR(addr), .MGMT_WDATA(wdata), .MGMT_RDATA(rdata), .MGMT_BUSY(busy),
    .EVENT_HIGH(ev_high), .EVENT_LOW_N(ev_low_n), .TRACK_STATE(trk), .WZ_SET(wz_set),
    .FUNC_START(start), .FUNC_DONE(done), .STRAP_PINS(pins), .STRAP_ADDR(straps),
    .GATED_BITS(gated), .WZ_BITS(wz), .PLAIN_RW_BIT(plain), .NODEF_BIT(nodef),
    .SOFT_RESET_ACTIVE(sra));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // pairs of reads: history first, then the live level
  task automatic rd2(input string nm, input logic [15:0] e1, input logic [15:0] e2);
    logic [15:0] d;
    sta.do_rd(REG_CTRL_IDX, d);
    chk(nm, e1, {d[LMAX_MSB_POS:LMAX_LSB_POS], 11'h0, d[LHIGH_POS], d[LLOW_POS]});
    sta.do_rd(REG_CTRL_IDX, d);
    chk(nm, e2, {d[LMAX_MSB_POS:LMAX_LSB_POS], 11'h0, d[LHIGH_POS], d[LLOW_POS]});
  endtask
  task automatic t_defaults;
    logic [15:0] d;
    sta.do_rd(REG_CTRL_IDX, d);
    chk("ctrl", 16'h00D8, d & 16'hFFFB);
    chk("straps", 16'h0015, {11'h0, straps});
    $display("defaults test done");
  endtask
  task automatic t_latch;
    ev_high = 1'b1;
    ev_low_n = 1'b0;
    sta.idle;
    ev_high = 1'b0;
    ev_low_n = 1'b1;
    sta.idle;
    rd2("latch", 16'h0002, 16'h0001);
    ev_high = 1'b1;
    ev_low_n = 1'b0;
    sta.do_rd(REG_CTRL_IDX, rdata_unused);
    ev_high = 1'b0;
    ev_low_n = 1'b1;
    rd2("latch same", 16'h0002, 16'h0001);
    $display("latch test done");
  endtask
  // latch-low stays at its live level of one here, so the lowest bit reads one
  task automatic t_lmax;
    trk = 3'h3;
    sta.idle;
    trk = 3'h2;
    sta.idle;
    rd2("lmax", 16'h6001, 16'h4001);
    trk = 3'h4;
    sta.idle;
    trk = 3'h1;
    sta.idle;
    rd2("lmax up", 16'h8001, 16'h2001);
    $display("latch max test done");
  endtask
  task automatic t_write;
    sta.do_wr(REG_CTRL_IDX, 16'h0300);
    chk("gated", 16'h0, gated);
    chk("wz", 16'h0, wz);
    sta.do_wr(REG_CTRL_IDX, 16'h00C0);
    chk("wz", 16'h0, wz);
    sta.do_wr(REG_STRAP_IDX, 16'h001F);
    chk("straps", 16'h0015, {11'h0, straps});
    sta.do_wr(REG_CTRL_IDX, 16'h4000);
    sta.do_wr(REG_CTRL_IDX, 16'h0200);
    chk("gated", 16'h2, gated);
    sta.do_wr(REG_CTRL_IDX, 16'h0104);
    chk("gated", 16'h2, gated);
    wz_set = 2'h1;
    sta.idle;
    wz_set = 2'h0;
    chk("wz set", 16'h1, wz);
    $display("write test done");
  endtask
  task automatic t_trigger;
    logic [15:0] d;
    fork
      sta.do_wr(REG_CTRL_IDX, 16'h0404);
      begin
        #1;
        chk("start", 16'h1, start);
      end
    join
    sta.do_rd(REG_CTRL_IDX, d);
    chk("trigger", 16'h1, d[TRIGGER_POS]);
    done = 1'b1;
    sta.idle;
    done = 1'b0;
    sta.do_rd(REG_CTRL_IDX, d);
    chk("trigger", 16'h0, d[TRIGGER_POS]);
    $display("trigger test done");
  endtask
  task automatic t_softrst;
    logic [15:0] d;
    pins = 5'h0A;
    sta.do_wr(REG_CTRL_IDX, 16'h8004);
    sta.do_rd(REG_CTRL_IDX, d);
    chk("busy", 16'h1, busy);
    chk("active", 16'h1, sra);
    chk("reset bit", 16'h1, d[SOFT_RST_POS]);
    for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
      sta.idle;
    end
    if (busy !== 1'b0) begin
      bad_count++;
      final_report;
    end
    chk("defaults", 16'h0007, {13'h0, plain, wz});
    chk("straps", 16'h000A, {11'h0, straps});
    chk("nodef", 16'h1, nodef);
    chk("active", 16'h0, sra);
    $display("software reset test done");
  endtask
  initial begin
    {ev_high, done, trk, wz_set} = '0;
    ev_low_n = 1'b1;
    pins = 5'h15;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_defaults;
    t_latch;
    t_lmax;
    t_write;
    t_trigger;
    t_softrst;
    final_report;
  end
endmodule
